/* File: hdl/dgr_regs.v */
// deflection geometry register bank with sync, drive and blanking control
`timescale 1ns/1ps
`include "dgr_map.vh"
module dgr_regs #(
   parameter BLANK_WIDTH = 7
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // register port from the serial control bus slave
   input wire regWrite,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata,
   output wire regHit,
   // sync, x-ray trip and flyback inputs
   input wire lineSyncIn,
   input wire frameSyncIn,
   input wire equalizerIn,
   input wire xrayTripIn,
   input wire vertFlybackOk,
   // line drive pin, open drain style
   input wire lineDriveReq,
   output wire lineDriveOut,
   output wire lineDriveOe,
   // events and status
   output wire lineSyncEdge,
   output wire frameSyncEdge,
   output wire xrayShutdown,
   output wire vertGuardBlank,
   output wire vertBlankOut,
   // horizontal settings to the analog section
   output wire [7:0] horizontalPosition,
   output wire hvCompActive,
   output wire compShiftDirection,
   output wire [1:0] compAmplitude,
   output wire [7:0] parallelogramEff,
   output wire [7:0] bowEff,
   // vertical settings
   output wire [7:0] verticalSize,
   output wire [7:0] verticalPosition,
   output wire [6:0] cLinearity,
   output wire [6:0] sLinearity,
   output wire rampRun,
   output wire [3:0] sideHvComp,
   output wire [3:0] verticalDriveComp,
   // east-west and focus settings
   output wire [6:0] horizontalSize,
   output wire [6:0] sideBulge,
   output wire [6:0] upperEdge,
   output wire [6:0] lowerEdge,
   output wire [6:0] keystone,
   output wire [6:0] focusAmplitude
);
   reg [7:0] horizontal_position_ff;
   reg [7:0] hcomp_ff;
   reg [7:0] para_ff;
   reg [7:0] bow_ff;
   reg [7:0] vertical_size_ff;
   reg [7:0] vcomp_ff;
   reg [7:0] clin_ff;
   reg [7:0] slin_ff;
   reg [7:0] vertical_position_ff;
   reg [7:0] hsize_ff;
   reg [7:0] bulge_ff;
   reg [7:0] upper_ff;
   reg [7:0] lower_ff;
   reg [7:0] keyst_ff;
   reg [7:0] focus_ff;
   reg [7:0] sync_ff;
   reg [7:0] vertical_blank_length_ff;
   reg xrayLatch_ff;
   reg [7:0] nxt_rdata;
   wire rawLineEdge;
   wire [BLANK_WIDTH-1:0] blankLines;

   // masks writes so unused positions never hold a one
   function [7:0] dgr_masked;
      input [7:0] data;
      input [7:0] mask;
      begin
         dgr_masked = data & mask;
      end
   endfunction

   // register bank, one write per selected offset
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         horizontal_position_ff <= `DGR_RST_ZERO;
         hcomp_ff <= `DGR_RST_HCOMP;
         para_ff <= `DGR_RST_CENTER8;
         bow_ff <= `DGR_RST_CENTER8;
         vertical_size_ff <= `DGR_RST_ZERO;
         vcomp_ff <= `DGR_RST_ZERO;
         clin_ff <= `DGR_RST_CENTER7;
         slin_ff <= `DGR_RST_ZERO;
         vertical_position_ff <= `DGR_RST_ZERO;
         hsize_ff <= `DGR_RST_ZERO;
         bulge_ff <= `DGR_RST_ZERO;
         upper_ff <= `DGR_RST_CENTER7;
         lower_ff <= `DGR_RST_CENTER7;
         keyst_ff <= `DGR_RST_CENTER7;
         focus_ff <= `DGR_RST_ZERO;
         sync_ff <= `DGR_RST_SYNC;
         vertical_blank_length_ff <= `DGR_RST_ZERO;
      end else if (regWrite) begin
         // unmapped offsets fall to the default and change nothing
         case (regAddr)
            `DGR_OFS_HORIZONTAL_POSITION: begin
               horizontal_position_ff <= regWdata;
            end
            `DGR_OFS_HCOMP: begin
               hcomp_ff <= regWdata;
            end
            `DGR_OFS_PARA: begin
               para_ff <= regWdata;
            end
            `DGR_OFS_BOW: begin
               bow_ff <= regWdata;
            end
            `DGR_OFS_VERTICAL_SIZE: begin
               vertical_size_ff <= regWdata;
            end
            `DGR_OFS_VCOMP: begin
               vcomp_ff <= regWdata;
            end
            // 7-bit fields drop bit 7 on the way in, so it reads zero
            `DGR_OFS_CLIN: begin
               clin_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_SLIN: begin
               slin_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_VERTICAL_POSITION: begin
               vertical_position_ff <= regWdata;
            end
            `DGR_OFS_HSIZE: begin
               hsize_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_BULGE: begin
               bulge_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_UPPER: begin
               upper_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_LOWER: begin
               lower_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_KEYST: begin
               keyst_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_FOCUS: begin
               focus_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            `DGR_OFS_SYNC: begin
               sync_ff <= dgr_masked(regWdata, `DGR_MASK_SYNC);
            end
            `DGR_OFS_VERTICAL_BLANK_LENGTH: begin
               vertical_blank_length_ff <= dgr_masked(regWdata, `DGR_MASK7);
            end
            default: begin
            end
         endcase
      end
   end

   // read mux; unmapped offsets read zero and regHit stays low
   always @* begin
      case (regAddr)
         `DGR_OFS_HORIZONTAL_POSITION: begin
            nxt_rdata = horizontal_position_ff;
         end
         `DGR_OFS_HCOMP: begin
            nxt_rdata = hcomp_ff;
         end
         `DGR_OFS_PARA: begin
            nxt_rdata = para_ff;
         end
         `DGR_OFS_BOW: begin
            nxt_rdata = bow_ff;
         end
         `DGR_OFS_VERTICAL_SIZE: begin
            nxt_rdata = vertical_size_ff;
         end
         `DGR_OFS_VCOMP: begin
            nxt_rdata = vcomp_ff;
         end
         `DGR_OFS_CLIN: begin
            nxt_rdata = clin_ff;
         end
         `DGR_OFS_SLIN: begin
            nxt_rdata = slin_ff;
         end
         `DGR_OFS_VERTICAL_POSITION: begin
            nxt_rdata = vertical_position_ff;
         end
         `DGR_OFS_HSIZE: begin
            nxt_rdata = hsize_ff;
         end
         `DGR_OFS_BULGE: begin
            nxt_rdata = bulge_ff;
         end
         `DGR_OFS_UPPER: begin
            nxt_rdata = upper_ff;
         end
         `DGR_OFS_LOWER: begin
            nxt_rdata = lower_ff;
         end
         `DGR_OFS_KEYST: begin
            nxt_rdata = keyst_ff;
         end
         `DGR_OFS_FOCUS: begin
            nxt_rdata = focus_ff;
         end
         `DGR_OFS_SYNC: begin
            nxt_rdata = sync_ff;
         end
         `DGR_OFS_VERTICAL_BLANK_LENGTH: begin
            nxt_rdata = vertical_blank_length_ff;
         end
         default: begin
            nxt_rdata = `DGR_RST_ZERO;
         end
      endcase
   end

   // read data is registered so the bus slave sees it one cycle later
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdata <= `DGR_RST_ZERO;
      end else begin
         regRdata <= nxt_rdata;
      end
   end

   // the bank is one contiguous window of offsets
   assign regHit = (regAddr >= `DGR_OFS_HORIZONTAL_POSITION) &&
      (regAddr <= `DGR_OFS_VERTICAL_BLANK_LENGTH);

   // sync edge detection with selectable polarity
   dgr_edge_detect lineDet (
      .clk(clk),
      .rst(rst),
      .syncIn(lineSyncIn),
      .polarity(sync_ff[`DGR_BIT_LPOL]),
      .leadEdge(rawLineEdge)
   );

   dgr_edge_detect frameDet (
      .clk(clk),
      .rst(rst),
      .syncIn(frameSyncIn),
      .polarity(sync_ff[`DGR_BIT_FPOL]),
      .leadEdge(frameSyncEdge)
   );

   // equalizing pulses are flagged by the sync separator; drop them here
   assign lineSyncEdge = rawLineEdge &
      ~(hcomp_ff[`DGR_BIT_EQREM] & equalizerIn);

   // x-ray trip latches until reset; disable bit masks the shutdown
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         xrayLatch_ff <= 1'b0;
      end else if (xrayTripIn) begin
         xrayLatch_ff <= 1'b1;
      end
   end

   assign xrayShutdown = xrayLatch_ff &
      ~hcomp_ff[`DGR_BIT_XRAYDIS];

   // line drive: released while off or shut down, the pull-up then holds it
   assign lineDriveOe = ~hcomp_ff[`DGR_BIT_LDOFF] & ~xrayShutdown;
   assign lineDriveOut = lineDriveReq;

   // horizontal settings
   assign horizontalPosition = horizontal_position_ff;
   assign hvCompActive = ~hcomp_ff[`DGR_BIT_HVEN_N];
   assign compShiftDirection = hcomp_ff[`DGR_BIT_SHIFTDIR];
   assign compAmplitude = hcomp_ff[`DGR_AMP_HI:`DGR_AMP_LO];
   // a disabled phase correction is presented as the neutral code
   assign parallelogramEff = hcomp_ff[`DGR_BIT_PHDIS] ?
      `DGR_RST_CENTER8 : para_ff;
   assign bowEff = hcomp_ff[`DGR_BIT_PHDIS] ?
      `DGR_RST_CENTER8 : bow_ff;

   // vertical settings
   assign verticalSize = vertical_size_ff;
   assign verticalPosition = vertical_position_ff;
   assign cLinearity = clin_ff[6:0];
   assign sLinearity = slin_ff[6:0];
   assign rampRun = ~sync_ff[`DGR_BIT_SERVICE_LINE];
   assign sideHvComp = sync_ff[`DGR_BIT_SIDEDIS] ?
      4'h0 : vcomp_ff[7:4];
   assign verticalDriveComp = sync_ff[`DGR_BIT_VDDIS] ?
      4'h0 : vcomp_ff[3:0];

   // guard blanks only when armed and the flyback is missing
   assign vertGuardBlank = ~sync_ff[`DGR_BIT_VGDIS] &
      ~vertFlybackOk;

   // east-west and focus
   assign horizontalSize = hsize_ff[6:0];
   assign sideBulge = bulge_ff[6:0];
   assign upperEdge = upper_ff[6:0];
   assign lowerEdge = lower_ff[6:0];
   assign keystone = keyst_ff[6:0];
   assign focusAmplitude = focus_ff[6:0];

   // vertical blanking pulse
   assign blankLines = vertical_blank_length_ff[BLANK_WIDTH-1:0];

   dgr_blank_gen #(
      .WIDTH(BLANK_WIDTH)
   ) blankGen (
      .clk(clk),
      .rst(rst),
      .frameStart(frameSyncEdge),
      .lineTick(lineSyncEdge),
      .lineCount(blankLines),
      .blankOut(vertBlankOut)
   );
endmodule

/* File: hdl/dgr_map.vh */
// register offsets, field positions and reset values of the deflection bank
`ifndef DGR_MAP_VH
`define DGR_MAP_VH
`define DGR_OFS_HORIZONTAL_POSITION 8'h41
`define DGR_OFS_HCOMP 8'h42
`define DGR_OFS_PARA 8'h43
`define DGR_OFS_BOW 8'h44
`define DGR_OFS_VERTICAL_SIZE 8'h45
`define DGR_OFS_VCOMP 8'h46
`define DGR_OFS_CLIN 8'h47
`define DGR_OFS_SLIN 8'h48
`define DGR_OFS_VERTICAL_POSITION 8'h49
`define DGR_OFS_HSIZE 8'h4a
`define DGR_OFS_BULGE 8'h4b
`define DGR_OFS_UPPER 8'h4c
`define DGR_OFS_LOWER 8'h4d
`define DGR_OFS_KEYST 8'h4e
`define DGR_OFS_FOCUS 8'h4f
`define DGR_OFS_SYNC 8'h50
`define DGR_OFS_VERTICAL_BLANK_LENGTH 8'h51
// horizontal compensation control fields
`define DGR_BIT_EQREM 7
`define DGR_BIT_XRAYDIS 6
`define DGR_BIT_LDOFF 5
`define DGR_BIT_PHDIS 4
`define DGR_BIT_HVEN_N 3
`define DGR_BIT_SHIFTDIR 2
`define DGR_AMP_HI 1
`define DGR_AMP_LO 0
// sync and protect fields
`define DGR_BIT_VGDIS 5
`define DGR_BIT_SIDEDIS 4
`define DGR_BIT_VDDIS 3
`define DGR_BIT_SERVICE_LINE 2
`define DGR_BIT_FPOL 1
`define DGR_BIT_LPOL 0
// reset values
`define DGR_RST_HCOMP 8'h20
`define DGR_RST_SYNC 8'h20
`define DGR_RST_CENTER8 8'h7f
`define DGR_RST_CENTER7 8'h3f
`define DGR_RST_ZERO 8'h00
// writable bit masks
`define DGR_MASK8 8'hff
`define DGR_MASK7 8'h7f
`define DGR_MASK_SYNC 8'h3f
`endif

/* File: hdl/dgr_edge_detect.v */
// polarity-selectable sync edge detector
`timescale 1ns/1ps
module dgr_edge_detect (
   // clock and reset
   input wire clk,
   input wire rst,
   // sync
   input wire syncIn,
   input wire polarity,
   // event
   output wire leadEdge
);
   reg syncDly_ff;
   wire active;
   wire activeDly;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         syncDly_ff <= 1'b0;
      end else begin
         syncDly_ff <= syncIn;
      end
   end

   // polarity 0 means negative going pulse
   assign active = polarity ? syncIn : ~syncIn;
   assign activeDly = polarity ? syncDly_ff : ~syncDly_ff;
   assign leadEdge = active & ~activeDly;
endmodule

/* File: hdl/dgr_blank_gen.v */
// vertical blanking pulse timer counted in lines
`timescale 1ns/1ps
module dgr_blank_gen #(
   parameter WIDTH = 7
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // events
   input wire frameStart,
   input wire lineTick,
   input wire [WIDTH-1:0] lineCount,
   // pulse
   output wire blankOut
);
   reg [WIDTH-1:0] remain_ff;
   reg blank_ff;
   reg [WIDTH-1:0] nxt_remain;
   reg nxt_blank;

   always @* begin
      nxt_remain = remain_ff;
      nxt_blank = blank_ff;
      if (frameStart) begin
         nxt_remain = lineCount;
         nxt_blank = (lineCount != {WIDTH{1'b0}});
      end else if (blank_ff && lineTick) begin
         nxt_remain = remain_ff - {{(WIDTH-1){1'b0}}, 1'b1};
         if (remain_ff == {{(WIDTH-1){1'b0}}, 1'b1}) begin
            nxt_blank = 1'b0;
         end
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         remain_ff <= {WIDTH{1'b0}};
         blank_ff <= 1'b0;
      end else begin
         remain_ff <= nxt_remain;
         blank_ff <= nxt_blank;
      end
   end

   assign blankOut = blank_ff;
endmodule

/* File: bench/dgr_host_model.sv */
// host side model driving the register port of the deflection bank
`timescale 1ns/1ps
module dgr_host_model (
   // clock
   input wire clk,
   // register port
   output logic regWrite,
   output logic [7:0] regAddr,
   output logic [7:0] regWdata,
   input wire [7:0] regRdata
);
   initial begin
      regWrite = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
   end
   // one byte per strobe, taken at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
      // released data is inverted so a stale byte cannot pass as good
      regWdata = ~d;
   endtask
   // read data is registered, so it is taken one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      @(posedge clk);
      #1;
      d = regRdata;
   endtask
   // protection stays off until the host clears its disable bit
   task automatic arm_vertical_guard(input logic [7:0] rest);
      wr(8'h50, rest & 8'hdf);
   endtask
endmodule

/* File: bench/dgr_regs_sva.sv */
// port level assertions for the deflection register bank
`timescale 1ns/1ps
module dgr_regs_sva (
   // clock and reset
   input wire clk,
   input wire rst,
   // register port
   input wire regWrite,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire [7:0] regRdata,
   input wire regHit,
   // drive and events
   input wire lineDriveReq,
   input wire lineDriveOut,
   input wire lineDriveOe,
   input wire lineSyncEdge,
   input wire frameSyncEdge,
   input wire xrayShutdown,
   input wire vertBlankOut,
   // settings
   input wire [7:0] horizontalPosition,
   input wire hvCompActive,
   input wire compShiftDirection,
   input wire [1:0] compAmplitude,
   input wire [7:0] parallelogramEff,
   input wire [7:0] bowEff,
   input wire rampRun,
   input wire [3:0] sideHvComp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire wr42 = regWrite && regAddr == 8'h42;
   wire wr50 = regWrite && regAddr == 8'h50;
   hit_decode_a: assert property (
      regHit == (regAddr >= 8'h41 && regAddr <= 8'h51))
      else $error("register hit decode wrong");
   unmapped_read_a: assert property (
      !regHit |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   horizontal_position_update_a: assert property (
      regWrite && regAddr == 8'h41 |=> horizontalPosition == $past(regWdata))
      else $error("horizontal position not updated");
   phase_neutral_a: assert property (
      wr42 && regWdata[4] |=> parallelogramEff == 8'h7f && bowEff == 8'h7f)
      else $error("phase corrections not neutral");
   comp_fields_a: assert property (wr42 |=>
      hvCompActive == !$past(regWdata[3]) &&
      compShiftDirection == $past(regWdata[2]) &&
      compAmplitude == $past(regWdata[1:0]))
      else $error("compensation fields wrong");
   drive_release_a: assert property (
      wr42 && regWdata[5] |=> !lineDriveOe)
      else $error("line drive not released");
   drive_follow_a: assert property (
      lineDriveOe |-> lineDriveOut == lineDriveReq)
      else $error("line drive does not follow request");
   xray_guard_a: assert property (
      wr42 && regWdata[6] |=> !xrayShutdown)
      else $error("shutdown while protection disabled");
   service_ramp_a: assert property (
      wr50 |=> rampRun == !$past(regWdata[2]))
      else $error("ramp run does not follow service bit");
   side_disable_a: assert property (
      wr50 && regWdata[4] |=> sideHvComp == 4'h0)
      else $error("side compensation not disabled");
   edge_pulse_a: assert property (
      lineSyncEdge |=> !lineSyncEdge)
      else $error("line edge longer than one cycle");
   blank_rise_a: assert property (
      $rose(vertBlankOut) |-> $past(frameSyncEdge))
      else $error("blank rose without frame edge");
   blank_fall_a: assert property (
      $fell(vertBlankOut) |-> $past(lineSyncEdge) || $past(frameSyncEdge))
      else $error("blank fell without line edge");
endmodule
bind dgr_regs dgr_regs_sva dgr_regs_sva_inst (.clk, .rst, .regWrite,
   .regAddr, .regWdata, .regRdata, .regHit, .lineDriveReq, .lineDriveOut,
   .lineDriveOe, .lineSyncEdge, .frameSyncEdge, .xrayShutdown, .vertBlankOut,
   .horizontalPosition, .hvCompActive, .compShiftDirection, .compAmplitude,
   .parallelogramEff, .bowEff, .rampRun, .sideHvComp);

/* File: bench/deflection_geometry_regs_tb.sv */
// self-checking bench for the deflection geometry register bank
`timescale 1ns/1ps
module deflection_geometry_regs_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic lineSyncIn = 1'b0;
   logic frameSyncIn = 1'b0;
   logic equalizerIn = 1'b0;
   logic xrayTripIn = 1'b0;
   logic vertFlybackOk = 1'b0;
   logic lineDriveReq = 1'b1;
   wire regWrite, regHit, lineDriveOut, lineDriveOe, lineSyncEdge;
   wire frameSyncEdge, xrayShutdown, vertGuardBlank, vertBlankOut;
   wire hvCompActive, compShiftDirection, rampRun;
   wire [7:0] regAddr, regWdata, regRdata, horizontalPosition;
   wire [7:0] parallelogramEff, bowEff;
   wire [3:0] sideHvComp, verticalDriveComp;
   wire [1:0] compAmplitude;
   wire [6:0] cLinearity;
   int failures = 0;
   int check_count = 0;
   int lineEdges = 0;
   int frameEdges = 0;
   int i;
   logic [7:0] a, v;
   always #25 clk = ~clk;
   dgr_host_model dgr_host_model_inst (.clk, .regWrite, .regAddr, .regWdata,
      .regRdata);
   dgr_regs dgr_regs_inst (.clk, .rst, .regWrite, .regAddr, .regWdata,
      .regRdata, .regHit, .lineSyncIn, .frameSyncIn, .equalizerIn,
      .xrayTripIn, .vertFlybackOk, .lineDriveReq, .lineDriveOut, .lineDriveOe,
      .lineSyncEdge, .frameSyncEdge, .xrayShutdown, .vertGuardBlank,
      .vertBlankOut, .horizontalPosition, .hvCompActive, .compShiftDirection,
      .compAmplitude, .parallelogramEff, .bowEff, .verticalSize(),
      .verticalPosition(), .cLinearity, .sLinearity(), .rampRun, .sideHvComp,
      .verticalDriveComp, .horizontalSize(), .sideBulge(), .upperEdge(),
      .lowerEdge(), .keystone(), .focusAmplitude());
   always @(posedge clk) begin
      if (lineSyncEdge === 1'b1) lineEdges <= lineEdges + 1;
      if (frameSyncEdge === 1'b1) frameEdges <= frameEdges + 1;
   end
   function automatic logic [7:0] rstVal(input logic [7:0] ad);
      case (ad)
         8'h42, 8'h50: rstVal = 8'h20;
         8'h43, 8'h44: rstVal = 8'h7f;
         8'h47, 8'h4c, 8'h4d, 8'h4e: rstVal = 8'h3f;
         default: rstVal = 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] wmask(input logic [7:0] ad);
      if (ad < 8'h41 || ad > 8'h51) wmask = 8'h00;
      else if (ad == 8'h50) wmask = 8'h3f;
      else if (ad == 8'h47 || ad == 8'h48 || ad >= 8'h4a) wmask = 8'h7f;
      else wmask = 8'hff;
   endfunction
   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one sync pulse at the given active level, then back to idle
   task automatic pulse(input logic ln, input logic act);
      @(posedge clk);
      #1;
      if (ln) lineSyncIn = act; else frameSyncIn = act;
      repeat (2) @(posedge clk);
      #1;
      if (ln) lineSyncIn = ~act; else frameSyncIn = ~act;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1;
      check("drive enable", 8'(lineDriveOe), 8'h00);
      rst = 1'b0;
      check("guard blank", 8'(vertGuardBlank), 8'h00);
      for (a = 8'h40; a <= 8'h52; a = a + 8'h01) begin
         dgr_host_model_inst.rd(a, v);
         check("reset value", v, rstVal(a));
         check("hit", 8'(regHit), 8'(wmask(a) != 8'h00));
      end
      for (i = 0; i < 2; i++) begin
         for (a = 8'h40; a <= 8'h52; a = a + 8'h01)
            dgr_host_model_inst.wr(a, i ? 8'h00 : 8'hff);
         for (a = 8'h40; a <= 8'h52; a = a + 8'h01) begin
            dgr_host_model_inst.rd(a, v);
            check("readback", v, i ? 8'h00 : wmask(a));
         end
         check("para", parallelogramEff, i ? 8'h00 : 8'h7f);
         check("bow", bowEff, i ? 8'h00 : 8'h7f);
         check("comp on", 8'(hvCompActive), 8'(i));
         check("ramp run", 8'(rampRun), 8'(i));
         check("drive enable", 8'(lineDriveOe), 8'(i));
         check("side comp", 8'(sideHvComp), 8'h00);
         check("guard blank", 8'(vertGuardBlank), 8'(i));
         check("horizontal_position", horizontalPosition, i ? 8'h00 : 8'hff);
         check("c lin", 8'(cLinearity), i ? 8'h00 : 8'h7f);
      end
      check("drive out", 8'(lineDriveOut), 8'h01);
      vertFlybackOk = 1'b1;
      #1;
      check("guard blank", 8'(vertGuardBlank), 8'h00);
      for (i = 0; i < 8; i++) begin
         dgr_host_model_inst.wr(8'h42, 8'(i));
         check("shift dir", 8'(compShiftDirection), 8'(i / 4));
         check("amplitude", 8'(compAmplitude), 8'(i % 4));
      end
      dgr_host_model_inst.wr(8'h46, 8'ha5);
      for (i = 0; i < 3; i++) begin
         dgr_host_model_inst.arm_vertical_guard(8'(i * 8));
         v = (i == 2) ? 8'h00 : 8'h0a;
         check("side comp", 8'(sideHvComp), v);
         v = (i == 1) ? 8'h00 : 8'h05;
         check("vdrive", 8'(verticalDriveComp), v);
      end
      for (i = 0; i < 2; i++) begin
         dgr_host_model_inst.wr(8'h50, 8'(i * 3));
         lineSyncIn = ~i[0];
         frameSyncIn = ~i[0];
         repeat (3) @(posedge clk);
         #1;
         lineEdges = 0;
         frameEdges = 0;
         pulse(1'b1, i[0]);
         pulse(1'b0, i[0]);
         check("line edges", 8'(lineEdges), 8'h01);
         check("frame edges", 8'(frameEdges), 8'h01);
      end
      dgr_host_model_inst.wr(8'h42, 8'h80);
      equalizerIn = 1'b1;
      lineEdges = 0;
      pulse(1'b1, 1'b1);
      check("equalizer cut", 8'(lineEdges), 8'h00);
      dgr_host_model_inst.wr(8'h42, 8'h00);
      pulse(1'b1, 1'b1);
      check("equalizer kept", 8'(lineEdges), 8'h01);
      equalizerIn = 1'b0;
      dgr_host_model_inst.wr(8'h51, 8'h83);
      pulse(1'b0, 1'b1);
      for (i = 0; i < 3; i++) begin
         check("blank hold", 8'(vertBlankOut), 8'h01);
         pulse(1'b1, 1'b1);
      end
      check("blank end", 8'(vertBlankOut), 8'h00);
      xrayTripIn = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("xray trip", 8'(xrayShutdown), 8'h01);
      check("drive enable", 8'(lineDriveOe), 8'h00);
      dgr_host_model_inst.wr(8'h42, 8'h40);
      check("xray off", 8'(xrayShutdown), 8'h00);
      end_sim();
   end
   initial begin
      #(50 * 4000);
      failures++;
      end_sim();
   end
endmodule
